// ==== include/lhcr_defs.svh ====
`ifndef LHCR_DEFS_SVH
`define LHCR_DEFS_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define LHCR_OFF_FAIL_CAPT  8'h3c
`define LHCR_OFF_COMPANY_ID 8'h40
`define LHCR_OFF_FLAGS_SET  8'h50
`define LHCR_OFF_FLAGS_CLR  8'h54

// ----------------------------------------------------------------------
// capture register fields
// ----------------------------------------------------------------------
`define LHCR_CAPT_BUS_MSB   31
`define LHCR_CAPT_BUS_LSB   22
`define LHCR_CAPT_NODE_MSB  21
`define LHCR_CAPT_NODE_LSB  16
`define LHCR_CAPT_OFFS_MSB  15
`define LHCR_CAPT_OFFS_LSB  0

// ----------------------------------------------------------------------
// host flag bit positions
// ----------------------------------------------------------------------
`define LHCR_BIT_BIB_OK     31
`define LHCR_BIT_SKIP_SWAP  30
`define LHCR_BIT_LATE_ACK   29
`define LHCR_RSVD_MSB       28
`define LHCR_RSVD_LSB       24
`define LHCR_BIT_PHY_OWNER  23
`define LHCR_BIT_LINK_ON    17

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define LHCR_RST_FLAG       1'b0
`define LHCR_RST_OWNER      1'b1
`define LHCR_RST_CAPT       32'h0000_0000
`define LHCR_RST_RDATA      32'h0000_0000
`define LHCR_RST_SYNC       3'h0

`endif

// ==== include/lhcr_pkg.sv ====
package lhcr_pkg;
  typedef logic [31:0] lhcr_word_t;
  typedef logic [7:0]  lhcr_addr_t;
endpackage

// ==== verif/lhcr_far_model.sv ====
`timescale 1ns/10ps
// ----------------------------------------------------------------------
// remote node and link-side event source
// ----------------------------------------------------------------------
module lhcr_far_model
(
  input  wire logic        clk_in,
  output logic             pw_err_out,
  output logic [9:0]       bus_out,
  output logic [5:0]       node_out,
  output logic [15:0]      offs_out,
  output logic             fetch_err_out,
  output logic             bus_reset_out,
  output logic             rom_rd_out,
  output logic             async_out,
  output logic             ee_load_out,
  output logic             ee_owner_out
);
  initial
  begin
    {pw_err_out, fetch_err_out, bus_reset_out, rom_rd_out, async_out, ee_load_out} = 6'h0;
    {ee_owner_out, bus_out, node_out, offs_out} = 33'h0;
  end
  // ev order: pw_err, fetch_err, bus_reset, rom_rd, async, ee_load
  task automatic fire(input logic [5:0] ev, input logic [32:0] d);
    @(posedge clk_in);
    {pw_err_out, fetch_err_out, bus_reset_out, rom_rd_out, async_out, ee_load_out} <= ev;
    {ee_owner_out, bus_out, node_out, offs_out} <= d;
    @(negedge clk_in);
  endtask
  // released data lines flip, so a late sample cannot pass by luck
  task automatic quiet();
    @(posedge clk_in);
    {pw_err_out, fetch_err_out, bus_reset_out, rom_rd_out, async_out, ee_load_out} <= 6'h0;
    {ee_owner_out, bus_out, node_out, offs_out} <= ~{ee_owner_out, bus_out, node_out, offs_out};
  endtask
endmodule // lhcr_far_model

// ==== verif/lhcr_regs_tb.sv ====
`timescale 1ns/10ps
module lhcr_regs_tb;
  localparam logic [31:0] CO_ID = 32'h0012_3400; // arbitrary value
  logic        ref_clk, rstn, g_rst, s_rst, psel, pen, pwr, pready, perr, perr_s;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pw_err, fetch_err, bus_rst, rom_rd, async_rq, ee_ld, ee_own;
  logic [9:0]  sbus;
  logic [5:0]  snode;
  logic [15:0] soff;
  logic        ok_o, swap_o, late_o, own_o, link_o, serve_o, terr_o, upd_o, acc_o, tardy_o, evt_o;
  logic [63:0] rv;
  int          bad_count, n_checks, seed, i, m_ok, m_swap, m_late, m_link, m_own;
  logic [31:0] m_capt[$];

  lhcr_regs #(.COMPANY_ID(CO_ID)) i_dut (
    .ref_clk_in(ref_clk), .rstn_in(rstn), .global_reset_in(g_rst), .soft_reset_in(s_rst),
    .psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(perr), .pw_err_in(pw_err),
    .pw_src_bus_in(sbus), .pw_src_node_in(snode), .pw_offset_hi_in(soff),
    .bib_fetch_err_in(fetch_err), .bus_reset_in(bus_rst), .rom_block_read_in(rom_rd),
    .async_req_in(async_rq), .eeprom_load_in(ee_ld), .eeprom_owner_in(ee_own),
    .bus_info_image_ok_out(ok_o), .skip_byte_swap_out(swap_o), .late_ack_permit_out(late_o),
    .phy_enh_config_owner_out(own_o), .link_on_out(link_o), .rom_read_serve_out(serve_o),
    .rom_read_type_err_out(terr_o), .rom_regs_update_out(upd_o), .rx_accept_out(acc_o),
    .tardy_ack_out(tardy_o), .ack_tardy_evt_out(evt_o));

  lhcr_far_model i_far (
    .clk_in(ref_clk), .pw_err_out(pw_err), .bus_out(sbus), .node_out(snode), .offs_out(soff),
    .fetch_err_out(fetch_err), .bus_reset_out(bus_rst), .rom_rd_out(rom_rd),
    .async_out(async_rq), .ee_load_out(ee_ld), .ee_owner_out(ee_own));

  always #10 ref_clk = ~ref_clk;

  // ----------------------------------------------------------------------
  // checking and bus tasks
  // ----------------------------------------------------------------------
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      $display("unexpected %s expected %h seen %h", n, e, g);
      bad_count++;
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge ref_clk);
    psel <= 1'b1; pen <= 1'b0; pwr <= w; paddr <= a; pwdata <= d;
    @(posedge ref_clk);
    pen <= 1'b1;
    k = 0;
    do
    begin
      @(posedge ref_clk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    rd = prdata;
    perr_s = perr;
    psel <= 1'b0; pen <= 1'b0;
    if (pready !== 1'b1)
    begin
      bad_count++;
      end_sim();
    end
  endtask
  function automatic logic [31:0] m_flags();
    return {m_ok[0], m_swap[0], m_late[0], 5'h0, m_own[0], 5'h0, m_link[0], 17'h0};
  endfunction
  task automatic mwr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    if (a == 8'h50)
    begin
      if (m_link == 0 && d[31]) m_ok = 1;
      m_swap |= d[30]; m_late |= d[29]; m_link |= d[17];
    end
    else if (a == 8'h54)
    begin
      if (d[30]) m_swap = 0;
      if (d[29]) m_late = 0;
      if (d[17]) m_link = 0;
    end
  endtask
  task automatic ck_regs();
    apb(1'b0, 8'h50, 32'h0);
    chk("flags_set", m_flags(), rd);
    apb(1'b0, 8'h54, 32'h0);
    chk("flags_clr", m_flags(), rd);
  endtask
  task automatic ck_lvl();
    logic [31:0] lv;
    lv = {ok_o, swap_o, late_o, 5'h0, own_o, 5'h0, link_o, 17'h0};
    chk("lvl", m_flags() & 32'he082_0000, lv);
  endtask
  task automatic ck_comb();
    chk("serve", rom_rd && m_link && m_ok, serve_o);
    chk("type_err", rom_rd && m_link && !m_ok, terr_o);
    chk("rom_upd", bus_rst && m_ok, upd_o);
    chk("rx", async_rq && m_link, acc_o);
    chk("tardy", async_rq && m_link && m_late, tardy_o);
    chk("evt", async_rq && m_link && m_late, evt_o);
  endtask

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    ref_clk = 0; rstn = 0; g_rst = 0; s_rst = 0; psel = 0; pen = 0; pwr = 0;
    paddr = 8'h0; pwdata = 32'h0; seed = 32'he74d;
    bad_count = 0; n_checks = 0; m_ok = 0; m_swap = 0; m_late = 0; m_link = 0; m_own = 1;
    repeat (20) @(posedge ref_clk);
    rstn <= 1'b1;
    ck_lvl();
    ck_regs();
    apb(1'b1, 8'h40, ~CO_ID);
    apb(1'b0, 8'h40, 32'h0);
    chk("company_id", CO_ID, rd);
    apb(1'b1, 8'h3c, 32'hffff_ffff);
    apb(1'b0, 8'h3c, 32'h0);
    chk("capt_ro", 32'h0, rd);
    apb(1'b0, 8'h44, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, perr_s});
    chk("unmapped_data", 32'h0, rd);
    mwr(8'h50, 32'hffbe_ffff);
    ck_regs();
    mwr(8'h54, 32'h0);
    ck_regs();
    mwr(8'h54, 32'hffbe_ffff);
    ck_regs();
    $display("test directed done");
    for (i = 0; i < 300; i++)
    begin
      rv = {$random(seed), $random(seed)};
      case (rv[63:61])
        // bench node is never bus manager; bits 28-24 and 22 never written
        3'h0: mwr(8'h50, rv[31:0] & 32'he0be_ffff);
        3'h1: mwr(8'h54, rv[31:0] & 32'he0be_ffff);
        3'h2, 3'h3:
        begin
          i_far.fire({rv[40], 1'b0, rv[41], rv[42], rv[43], 1'b0}, rv[32:0]);
          ck_comb();
          if (rv[40]) m_capt.push_back(rv[31:0]);
          i_far.quiet();
          if (m_capt.size() > 0)
          begin
            apb(1'b0, 8'h3c, 32'h0);
            chk("capture", m_capt.pop_front(), rd);
          end
        end
        3'h4:
        begin
          i_far.fire(6'h10, rv[32:0]);
          ck_comb();
          i_far.quiet();
          m_ok = 0;
        end
        3'h5:
        begin
          @(posedge ref_clk);
          s_rst <= 1'b1;
          @(posedge ref_clk);
          s_rst <= 1'b0;
          m_ok = 0; m_swap = 0; m_late = 0; m_link = 0;
        end
        3'h6:
        begin
          i_far.fire(6'h01, rv[32:0]);
          i_far.quiet();
          m_own = rv[32];
        end
        default: ck_regs();
      endcase
      @(negedge ref_clk);
      ck_lvl();
    end
    $display("test random done");
    i_far.fire(6'h01, 33'h0);
    i_far.quiet();
    m_own = 0;
    mwr(8'h50, 32'he002_0000);
    @(negedge ref_clk);
    ck_lvl();
    @(posedge ref_clk);
    g_rst <= 1'b1;
    repeat (5) @(posedge ref_clk);
    m_ok = 0; m_swap = 0; m_late = 0; m_link = 0; m_own = 1;
    @(negedge ref_clk);
    ck_lvl();
    @(posedge ref_clk);
    g_rst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    ck_regs();
    $display("test global reset done");
    end_sim();
  end
endmodule // lhcr_regs_tb

// ==== verilog/lhcr_regs.sv ====
// The APB register port was decided locally.
`timescale 1ns/10ps
`include "lhcr_defs.svh"
// Summary of operation
// RULE1 - on posted write failure store bus number 31-22, node number 21-16
// RULE2 - on posted write failure store upper destination offset in 15-0
// RULE3 - capture register read-only, updated only by posted write failure
// RULE4 - company identifier register returns a fixed constant, writes ignored
// RULE5 - ones at set address set flags, at clear address clear; both read
// RULE6 - image-ok flag enables serving config ROM block reads and updates
// RULE7 - image-ok low: config ROM block reads get type-error acknowledge
// RULE8 - image-ok low: bus reset leaves ROM mapping, header, options unchanged
// RULE9 - software sets image-ok only while link-on is low
// RULE10 - image-ok cleared by hardware reset, software reset, fetch error
// RULE11 - bit 30 selects byte swapping of DMA and physical data
// RULE12 - late-ack permit set: async packets to node get tardy acknowledge
// RULE13 - every tardy acknowledge raises the tardy event toward interrupt logic
// RULE14 - software clears tardy event and unmasks wake events before D1
// RULE15 - software keeps late-ack permit clear while acting as bus manager
// RULE16 - bits 28-24 of host flags always read zero
// RULE17 - phy ownership flag read-only, defaults one, loaded from EEPROM
// RULE18 - software touches phy enhancements only when ownership flag is one
// RULE19 - link-on low disconnects from bus at once; any reset clears it
// RULE20 - phy ownership flag reset only by global hardware reset
// RULE21 - writing zero at set or clear address leaves flag unchanged
module lhcr_regs
#(
  parameter logic [31:0] COMPANY_ID = 32'h00a5_5a00 // arbitrary neutral value
)
(
  input  wire logic        ref_clk_in,
  input  wire logic        rstn_in,
  input  wire logic        global_reset_in,
  input  wire logic        soft_reset_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  input  wire logic        pw_err_in,
  input  wire logic [9:0]  pw_src_bus_in,
  input  wire logic [5:0]  pw_src_node_in,
  input  wire logic [15:0] pw_offset_hi_in,
  input  wire logic        bib_fetch_err_in,
  input  wire logic        bus_reset_in,
  input  wire logic        rom_block_read_in,
  input  wire logic        async_req_in,
  input  wire logic        eeprom_load_in,
  input  wire logic        eeprom_owner_in,
  output logic             bus_info_image_ok_out,
  output logic             skip_byte_swap_out,
  output logic             late_ack_permit_out,
  output logic             phy_enh_config_owner_out,
  output logic             link_on_out,
  output logic             rom_read_serve_out,
  output logic             rom_read_type_err_out,
  output logic             rom_regs_update_out,
  output logic             rx_accept_out,
  output logic             tardy_ack_out,
  output logic             ack_tardy_evt_out
);

  if ((^COMPANY_ID) === 1'bx)
  begin : g_id_check
    $error("company identifier must be a defined constant");
  end

  // ----------------------------------------------------------------------
  // global reset pin synchroniser
  // ----------------------------------------------------------------------
  logic [2:0] hwrst_sync_r;
  logic       hwrst_hold_r;
  // a change only counts once flops two and three agree
  wire        hwrst_act = (hwrst_sync_r[1] == hwrst_sync_r[2]) ? hwrst_sync_r[2]
                                                                 : hwrst_hold_r;

  always_ff @(posedge ref_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      hwrst_sync_r <= `LHCR_RST_SYNC;
      hwrst_hold_r <= `LHCR_RST_FLAG;
    end
    else
    begin
      hwrst_sync_r <= {hwrst_sync_r[1:0], global_reset_in};
      hwrst_hold_r <= hwrst_act;
    end
  end

  // ----------------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------------
  function automatic logic hit(input lhcr_pkg::lhcr_addr_t a,
                               input lhcr_pkg::lhcr_addr_t off);
    hit = (a == off);
  endfunction

  wire setup_ph  = psel_in & ~penable_in;
  wire access_ph = psel_in & penable_in;
  wire hit_capt  = hit(paddr_in, `LHCR_OFF_FAIL_CAPT);
  wire hit_id    = hit(paddr_in, `LHCR_OFF_COMPANY_ID);
  wire hit_set   = hit(paddr_in, `LHCR_OFF_FLAGS_SET);
  wire hit_clr   = hit(paddr_in, `LHCR_OFF_FLAGS_CLR);
  wire mapped    = hit_capt | hit_id | hit_set | hit_clr;
  wire wr_set    = access_ph & pwrite_in & hit_set;
  wire wr_clr    = access_ph & pwrite_in & hit_clr;
  wire any_rst   = hwrst_act | soft_reset_in;

  // zero wait states: every access completes in its first access cycle
  assign pready_out  = 1'b1;
  assign pslverr_out = access_ph & ~mapped;

  // ----------------------------------------------------------------------
  // failed posted write capture
  // ----------------------------------------------------------------------
  lhcr_pkg::lhcr_word_t capt_r;
  lhcr_pkg::lhcr_word_t capt_nxt;

  // writes at this offset are dropped: only the error path updates it
  assign capt_nxt = pw_err_in ? {pw_src_bus_in, pw_src_node_in, pw_offset_hi_in}
                              : capt_r; // [RULE1] [RULE2] [RULE3]

  always_ff @(posedge ref_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      capt_r <= `LHCR_RST_CAPT;
    else
      capt_r <= capt_nxt;
  end

  // ----------------------------------------------------------------------
  // host flags
  // ----------------------------------------------------------------------
  logic bib_ok_r, bib_ok_nxt;
  logic swap_r, swap_nxt;
  logic late_r, late_nxt;
  logic owner_r, owner_nxt;
  logic link_r, link_nxt;

  function automatic logic set_clr(input logic q, input logic s, input logic c);
    set_clr = (q | s) & ~c; // [RULE5] [RULE21]
  endfunction

  // image-ok has no clear address; set refused while the link is on
  wire bib_set = wr_set & pwdata_in[`LHCR_BIT_BIB_OK] & ~link_r; // [RULE9]
  // hardware clears beat a software set in the same cycle
  assign bib_ok_nxt = (any_rst | bib_fetch_err_in) ? `LHCR_RST_FLAG
                                                  : (bib_ok_r | bib_set); // [RULE10]
  assign swap_nxt = any_rst ? `LHCR_RST_FLAG
                            : set_clr(swap_r, wr_set & pwdata_in[`LHCR_BIT_SKIP_SWAP],
                                      wr_clr & pwdata_in[`LHCR_BIT_SKIP_SWAP]);
  assign late_nxt = any_rst ? `LHCR_RST_FLAG
                            : set_clr(late_r, wr_set & pwdata_in[`LHCR_BIT_LATE_ACK],
                                      wr_clr & pwdata_in[`LHCR_BIT_LATE_ACK]);
  assign link_nxt = any_rst ? `LHCR_RST_FLAG
                            : set_clr(link_r, wr_set & pwdata_in[`LHCR_BIT_LINK_ON],
                                      wr_clr & pwdata_in[`LHCR_BIT_LINK_ON]); // [RULE19]
  // soft reset deliberately absent here
  assign owner_nxt = hwrst_act ? `LHCR_RST_OWNER
                   : (eeprom_load_in ? eeprom_owner_in : owner_r); // [RULE17] [RULE20]

  always_ff @(posedge ref_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      bib_ok_r <= `LHCR_RST_FLAG;
      swap_r   <= `LHCR_RST_FLAG;
      late_r   <= `LHCR_RST_FLAG;
      link_r   <= `LHCR_RST_FLAG;
      owner_r  <= `LHCR_RST_OWNER;
    end
    else
    begin
      bib_ok_r <= bib_ok_nxt;
      swap_r   <= swap_nxt;
      late_r   <= late_nxt;
      link_r   <= link_nxt;
      owner_r  <= owner_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------------
  lhcr_pkg::lhcr_word_t flags_word;
  lhcr_pkg::lhcr_word_t rd_mux;
  lhcr_pkg::lhcr_word_t rdata_r;

  always_comb
  begin
    flags_word = 32'h0000_0000; // [RULE16]
    flags_word[`LHCR_BIT_BIB_OK]    = bib_ok_r;
    flags_word[`LHCR_BIT_SKIP_SWAP] = swap_r;
    flags_word[`LHCR_BIT_LATE_ACK]  = late_r;
    flags_word[`LHCR_BIT_PHY_OWNER] = owner_r;
    flags_word[`LHCR_BIT_LINK_ON]   = link_r;
  end

  assign rd_mux = hit_capt            ? capt_r
                : hit_id              ? COMPANY_ID // [RULE4]
                : (hit_set | hit_clr) ? flags_word // [RULE5]
                : 32'h0000_0000;

  // sampled in setup so the data is a flop output during access
  always_ff @(posedge ref_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      rdata_r <= `LHCR_RST_RDATA;
    else if (setup_ph)
      rdata_r <= rd_mux;
  end

  assign prdata_out = rdata_r;

  // ----------------------------------------------------------------------
  // link-side controls
  // ----------------------------------------------------------------------
  assign bus_info_image_ok_out    = bib_ok_r;
  assign skip_byte_swap_out       = swap_r; // [RULE11]
  assign late_ack_permit_out      = late_r;
  assign phy_enh_config_owner_out = owner_r;
  assign link_on_out              = link_r;
  assign rx_accept_out            = async_req_in & link_r; // [RULE19]
  assign rom_read_serve_out       = rom_block_read_in & link_r & bib_ok_r; // [RULE6]
  assign rom_read_type_err_out    = rom_block_read_in & link_r & ~bib_ok_r; // [RULE7]
  assign rom_regs_update_out      = bus_reset_in & bib_ok_r; // [RULE8]
  // tardy only while connected; the event mirrors every tardy ack
  assign tardy_ack_out            = async_req_in & link_r & late_r; // [RULE12]
  assign ack_tardy_evt_out        = tardy_ack_out; // [RULE13]

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rstn_in);

  property p_capt_hi;
    pw_err_in |=> capt_r[31:16] == $past({pw_src_bus_in, pw_src_node_in});
  endproperty
  a_capt_hi: assert property (p_capt_hi) // [RULE1]
    else $error("requester id not captured");

  property p_capt_lo;
    pw_err_in |=> capt_r[15:0] == $past(pw_offset_hi_in);
  endproperty
  a_capt_lo: assert property (p_capt_lo) // [RULE2]
    else $error("upper offset not captured");

  property p_capt_hold;
    !pw_err_in |=> $stable(capt_r);
  endproperty
  a_capt_hold: assert property (p_capt_hold) // [RULE3]
    else $error("capture changed without error");

  property p_id_read;
    setup_ph && hit_id ##1 access_ph |-> prdata_out == COMPANY_ID;
  endproperty
  a_id_read: assert property (p_id_read) // [RULE4]
    else $error("company id read wrong");

  property p_set_clr;
    (wr_clr && pwdata_in[29] && !any_rst) |=> !late_ack_permit_out ##1
      (late_ack_permit_out == $past(late_r) || $past(wr_set));
  endproperty
  a_set_clr: assert property (p_set_clr) // [RULE5]
    else $error("clear address did not clear");

  property p_rom_err;
    rom_block_read_in && link_on_out && !bus_info_image_ok_out
      |-> rom_read_type_err_out && !rom_read_serve_out;
  endproperty
  a_rom_err: assert property (p_rom_err) // [RULE7]
    else $error("rom read not refused");

  property p_bib_fetch;
    bib_fetch_err_in |=> !bus_info_image_ok_out;
  endproperty
  a_bib_fetch: assert property (p_bib_fetch) // [RULE10]
    else $error("fetch error left image-ok set");

  property p_tardy;
    async_req_in && link_on_out && late_ack_permit_out
      |-> tardy_ack_out && ack_tardy_evt_out;
  endproperty
  a_tardy: assert property (p_tardy) // [RULE13]
    else $error("tardy ack without event");

  property p_rsvd;
    setup_ph && (hit_set || hit_clr) |=> prdata_out[28:24] == 5'h00;
  endproperty
  a_rsvd: assert property (p_rsvd) // [RULE16]
    else $error("reserved bits nonzero");

  property p_owner_soft;
    soft_reset_in && !hwrst_act && !eeprom_load_in |=> $stable(phy_enh_config_owner_out);
  endproperty
  a_owner_soft: assert property (p_owner_soft) // [RULE20]
    else $error("soft reset touched owner flag");

  property p_link_off;
    !link_on_out |-> !rx_accept_out && !tardy_ack_out && !rom_read_serve_out;
  endproperty
  a_link_off: assert property (p_link_off) // [RULE19]
    else $error("traffic while link off");

  property p_zero_keep;
    wr_set && !pwdata_in[30] && !any_rst |=> $stable(skip_byte_swap_out);
  endproperty
  a_zero_keep: assert property (p_zero_keep) // [RULE21]
    else $error("zero write changed flag");

  c_capture: cover property (pw_err_in ##1 setup_ph && hit_capt);
  c_bib_set: cover property (bib_set ##1 bus_info_image_ok_out);
  c_tardy:   cover property (tardy_ack_out);
  c_unmap:   cover property (pslverr_out);

endmodule // lhcr_regs
